// ### common/timer_wave_pkg.sv
`default_nettype none
package timer_wave_pkg;

   // register byte offsets on the register port
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_COUNT = 8'h10;
   localparam logic [7:0] OFS_CMP_A = 8'h14;
   localparam logic [7:0] OFS_CMP_B = 8'h18;
   localparam logic [7:0] OFS_CMP_C = 8'h1C;
   localparam logic [7:0] OFS_STATUS = 8'h20;

   // control register command bits (write only)
   localparam int CTRL_CLK_ON_BIT = 0;
   localparam int CTRL_CLK_OFF_BIT = 1;
   localparam int CTRL_SOFT_TRIG_BIT = 2;

   // status register bits (read only)
   localparam int STAT_CLK_ON_BIT = 16;
   localparam int STAT_MIRROR_A_BIT = 17;
   localparam int STAT_MIRROR_B_BIT = 18;
   localparam int STAT_STOPPED_BIT = 19;

   // reset values
   localparam logic [31:0] MODE_RESET = 32'h0000_0000;
   localparam logic [15:0] VALUE_RESET = 16'h0000;

   // output action codes
   typedef enum logic [1:0] {
      ACT_NONE = 2'b00,
      ACT_SET = 2'b01,
      ACT_CLEAR = 2'b10,
      ACT_TOGGLE = 2'b11
   } act_e;

   // event edge choice
   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } edge_e;

   // counting direction of the triangle shape
   typedef enum logic {
      DIR_UP = 1'b0,
      DIR_DOWN = 1'b1
   } dir_e;

   // channel mode register, waveform layout, msb first
   typedef struct packed {
      act_e out_b_action_on_soft_trigger; // 31:30
      act_e out_b_action_on_event;        // 29:28
      act_e out_b_action_on_c_match;      // 27:26
      act_e out_b_action_on_b_match;      // 25:24
      act_e out_a_action_on_soft_trigger; // 23:22
      act_e out_a_action_on_event;        // 21:20
      act_e out_a_action_on_c_match;      // 19:18
      act_e out_a_action_on_a_match;      // 17:16
      logic waveform_mode_sel;            // 15
      logic auto_trigger_on_c;            // 14, high bit of wave_shape_sel
      logic triangle_count;               // 13, low bit of wave_shape_sel
      logic event_restart_en;             // 12
      logic [1:0] event_source_sel;       // 11:10
      edge_e event_edge_sel;              // 9:8
      logic disable_on_c_match;           // 7
      logic stop_on_c_match;              // 6
      logic [1:0] clock_gate_sel;         // 5:4
      logic count_edge_invert;            // 3
      logic [2:0] clock_source_sel;       // 2:0
   } mode_s;

   // new pin level after an action
   function automatic logic apply_action(act_e act, logic cur);
      case (act)
         ACT_SET: apply_action = 1'b1;
         ACT_CLEAR: apply_action = 1'b0;
         ACT_TOGGLE: apply_action = ~cur;
         default: apply_action = cur;
      endcase
   endfunction : apply_action

   // is this transition one the edge choice asks for
   function automatic logic edge_seen(edge_e sel, logic prev, logic now);
      case (sel)
         EDGE_RISE: edge_seen = ~prev & now;
         EDGE_FALL: edge_seen = prev & ~now;
         EDGE_BOTH: edge_seen = prev ^ now;
         default: edge_seen = 1'b0;
      endcase
   endfunction : edge_seen

   // highest priority source with a real action wins:
   // software trigger, then event, then c match, then own match
   function automatic act_e pick_action(logic sw, logic ev, logic cm,
                                        logic om, act_e a_sw, act_e a_ev,
                                        act_e a_cm, act_e a_om);
      if (sw && a_sw != ACT_NONE)
         pick_action = a_sw;
      else if (ev && a_ev != ACT_NONE)
         pick_action = a_ev;
      else if (cm && a_cm != ACT_NONE)
         pick_action = a_cm;
      else if (om)
         pick_action = a_om;
      else
         pick_action = ACT_NONE;
   endfunction : pick_action

endpackage : timer_wave_pkg
`default_nettype wire

// ### logic/timer_channel_waveform_mode.sv
// Overview of operation
// - three bits pick internal or external clock
// - invert bit selects falling count edge
// - gate field ANDs clock with external input
// - stop bit halts clock on c match
// - disable bit disables clock on c match
// - edge field chooses which event transitions count
// - source field picks io_b or external event
// - io_b as event source is input only
// - restart bit lets event reset and start counter
// - shape field: triangle count, auto c trigger
// - bit fifteen selects waveform versus capture mode
// - a match action drives io_a
// - c match action drives io_a
// - event action drives io_a
// - software trigger action drives io_a
// - b match action drives io_b
// - c match action drives io_b
// - event action drives io_b
// - software trigger action drives io_b
// - live count readable, upper bits zero
// - a and b writable only in waveform mode
// - c value always readable and writable
// - software trigger resets counter, clears a c match stop
`timescale 1ns/1ps
`default_nettype none
module timer_channel_waveform_mode
   import timer_wave_pkg::*;
#(
   parameter int CNT_WIDTH = 16, // counter and compare width
   parameter int ADDR_WIDTH = 8  // register port address width
)(
   input wire logic clk_i,                     // system clock
   input wire logic rst_i,                     // sync reset, high
   input wire logic [ADDR_WIDTH-1:0] addr_i,   // register byte address
   input wire logic [31:0] wdata_i,            // write data
   input wire logic wr_i,                      // write strobe
   input wire logic rd_i,                      // read strobe
   output logic [31:0] rdata_o,                // read data, next cycle
   input wire logic [4:0] internal_clock_i,    // internal clock levels
   input wire logic [2:0] ext_clock_i,         // external clock levels
   input wire logic channel_io_a_i,            // io_a pin level
   output logic channel_io_a_o,                // io_a drive level
   output logic channel_io_a_oe_o,             // io_a driven
   input wire logic channel_io_b_i,            // io_b pin level
   output logic channel_io_b_o,                // io_b drive level
   output logic channel_io_b_oe_o              // io_b driven
);

   // the decode and status layout assume these limits
   if (CNT_WIDTH < 2 || CNT_WIDTH > 16)
      $error("CNT_WIDTH must lie between 2 and 16");
   if (ADDR_WIDTH < 6 || ADDR_WIDTH > 8)
      $error("ADDR_WIDTH must lie between 6 and 8");

   localparam logic [CNT_WIDTH-1:0] CNT_ZERO = VALUE_RESET[CNT_WIDTH-1:0];
   localparam logic [CNT_WIDTH-1:0] CNT_ONE = CNT_WIDTH'(1);
   localparam logic [CNT_WIDTH-1:0] CNT_MAX = {CNT_WIDTH{1'b1}};

   // register state
   mode_s mode, next_mode;                          // channel mode
   logic [CNT_WIDTH-1:0] cmp_a, next_cmp_a;         // compare a
   logic [CNT_WIDTH-1:0] cmp_b, next_cmp_b;         // compare b
   logic [CNT_WIDTH-1:0] cmp_c, next_cmp_c;         // compare c
   logic [31:0] next_rdata;                         // read answer

   // counter state
   logic [CNT_WIDTH-1:0] count, next_count;         // live count
   dir_e dir, next_dir;                             // triangle direction
   logic clk_enabled, next_clk_enabled;             // on/off by command
   logic clk_stopped, next_clk_stopped;             // halted by c match
   logic clk_prev, next_clk_prev;                   // last gated level
   logic evt_prev, next_evt_prev;                   // last event level

   // pin state
   logic out_a, next_out_a;                         // io_a level
   logic out_b, next_out_b;                         // io_b level
   logic oe_a, next_oe_a;                           // io_a enable
   logic oe_b, next_oe_b;                           // io_b enable

   // decoded strobes and derived terms
   logic [7:0] addr8;                               // address, byte wide
   logic wave;                                      // waveform mode on
   logic b_is_output;                               // io_b makes waveform
   logic clk_on_cmd, clk_off_cmd, soft_trig;        // control commands
   logic [7:0] clk_srcs;                            // clock candidates
   logic src_level, gate_level, gated_level;        // clock path
   logic tick_edge, running, tick;                  // count edge
   logic evt_level, evt_hit, restart;               // external event
   logic [CNT_WIDTH-1:0] step;                      // count after a tick
   dir_e step_dir;                                  // direction after it
   logic a_match, b_match, c_match;                 // compare hits
   logic mirror_a, mirror_b;                        // pin mirrors

   assign addr8 = 8'(addr_i);
   assign wave = mode.waveform_mode_sel;
   // io_b only drives when it is not the event input
   assign b_is_output = wave && mode.event_source_sel != 2'b00;

   // control register is write only; commands are one-cycle pulses
   assign clk_on_cmd = wr_i && addr8 == OFS_CONTROL
                       && wdata_i[CTRL_CLK_ON_BIT];
   assign clk_off_cmd = wr_i && addr8 == OFS_CONTROL
                        && wdata_i[CTRL_CLK_OFF_BIT];
   assign soft_trig = wr_i && addr8 == OFS_CONTROL
                      && wdata_i[CTRL_SOFT_TRIG_BIT];

   // pick the counter clock source, then the optional gate
   assign clk_srcs = {ext_clock_i, internal_clock_i};
   assign src_level = clk_srcs[mode.clock_source_sel];

   always_comb
   begin
      // gate code 0 leaves the clock free
      case (mode.clock_gate_sel)
         2'b01: gate_level = ext_clock_i[0];
         2'b10: gate_level = ext_clock_i[1];
         2'b11: gate_level = ext_clock_i[2];
         default: gate_level = 1'b1;
      endcase
   end

   assign gated_level = src_level & gate_level;

   // source clocks are sampled levels, so an edge is a change seen
   // against the last sample; they must be slower than clk_i/2
   assign tick_edge = mode.count_edge_invert ?
                      (clk_prev & ~gated_level) :
                      (~clk_prev & gated_level);
   assign running = clk_enabled && !clk_stopped;
   assign tick = tick_edge && running;

   // event source: io_b pin or one external clock line
   always_comb
   begin
      case (mode.event_source_sel)
         2'b01: evt_level = ext_clock_i[0];
         2'b10: evt_level = ext_clock_i[1];
         2'b11: evt_level = ext_clock_i[2];
         default: evt_level = channel_io_b_i;
      endcase
   end

   assign evt_hit = edge_seen(mode.event_edge_sel, evt_prev,
                              evt_level);
   // an event only touches the counter when restart is on
   assign restart = evt_hit && mode.event_restart_en && wave;

   // value the counter would take on this tick
   always_comb
   begin
      step = count + CNT_ONE;
      step_dir = dir;
      if (wave && mode.triangle_count)
      begin
         // turn at the top: c with auto trigger, else full scale
         if (dir == DIR_UP)
         begin
            if (count == (mode.auto_trigger_on_c ? cmp_c : CNT_MAX))
            begin
               step = count - CNT_ONE;
               step_dir = DIR_DOWN;
            end
         end
         else if (count == CNT_ZERO)
         begin
            step = CNT_ONE;
            step_dir = DIR_UP;
         end
         else
         begin
            step = count - CNT_ONE;
         end
      end
      else if (mode.auto_trigger_on_c && count == cmp_c)
      begin
         // up shape with auto trigger restarts after c
         step = CNT_ZERO;
      end
   end

   // a match is the tick on which the counter arrives at the value
   assign a_match = tick && step == cmp_a;
   assign b_match = tick && step == cmp_b;
   assign c_match = tick && wave && step == cmp_c;

   // register file next values
   always_comb
   begin
      next_mode = mode;
      next_cmp_a = cmp_a;
      next_cmp_b = cmp_b;
      next_cmp_c = cmp_c;
      next_rdata = 32'h0000_0000;
      if (wr_i)
      begin
         case (addr8)
            OFS_MODE: next_mode = mode_s'(wdata_i);
            // a and b are locked while capture mode is selected
            OFS_CMP_A:
               if (wave)
                  next_cmp_a = wdata_i[CNT_WIDTH-1:0];
            OFS_CMP_B:
               if (wave)
                  next_cmp_b = wdata_i[CNT_WIDTH-1:0];
            OFS_CMP_C: next_cmp_c = wdata_i[CNT_WIDTH-1:0];
            default: next_mode = mode; // unmapped writes ignored
         endcase
      end
      if (rd_i)
      begin
         case (addr8)
            OFS_MODE: next_rdata = mode;
            OFS_COUNT: next_rdata = 32'(count);
            OFS_CMP_A: next_rdata = 32'(cmp_a);
            OFS_CMP_B: next_rdata = 32'(cmp_b);
            OFS_CMP_C: next_rdata = 32'(cmp_c);
            OFS_STATUS:
            begin
               next_rdata[STAT_CLK_ON_BIT] = clk_enabled;
               next_rdata[STAT_MIRROR_A_BIT] = mirror_a;
               next_rdata[STAT_MIRROR_B_BIT] = mirror_b;
               next_rdata[STAT_STOPPED_BIT] = clk_stopped;
            end
            default: next_rdata = 32'h0000_0000; // unmapped reads zero
         endcase
      end
   end

   // register file flops
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mode <= mode_s'(MODE_RESET);
         cmp_a <= CNT_ZERO;
         cmp_b <= CNT_ZERO;
         cmp_c <= CNT_ZERO;
         rdata_o <= 32'h0000_0000;
      end
      else
      begin
         mode <= next_mode;
         cmp_a <= next_cmp_a;
         cmp_b <= next_cmp_b;
         cmp_c <= next_cmp_c;
         rdata_o <= next_rdata;
      end
   end

   // counter and clock control next values
   always_comb
   begin
      next_count = count;
      next_dir = dir;
      next_clk_prev = gated_level;
      next_evt_prev = evt_level;
      next_clk_enabled = clk_enabled;
      next_clk_stopped = clk_stopped;
      // a disable command beats a same-cycle enable command
      if (clk_off_cmd || (c_match && mode.disable_on_c_match))
         next_clk_enabled = 1'b0;
      else if (clk_on_cmd)
         next_clk_enabled = 1'b1;
      if (soft_trig || restart)
      begin
         // trigger wins over a tick in the same cycle
         next_count = CNT_ZERO;
         next_dir = DIR_UP;
         next_clk_stopped = 1'b0;
      end
      else
      begin
         if (tick)
         begin
            next_count = step;
            next_dir = step_dir;
         end
         if (c_match && mode.stop_on_c_match)
            next_clk_stopped = 1'b1;
      end
   end

   // counter flops
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count <= CNT_ZERO;
         dir <= DIR_UP;
         clk_enabled <= 1'b0;
         clk_stopped <= 1'b0;
         clk_prev <= 1'b0;
         evt_prev <= 1'b0;
      end
      else
      begin
         count <= next_count;
         dir <= next_dir;
         clk_enabled <= next_clk_enabled;
         clk_stopped <= next_clk_stopped;
         clk_prev <= next_clk_prev;
         evt_prev <= next_evt_prev;
      end
   end

   // mirrors show the driven level, else the pin
   assign mirror_a = oe_a ? out_a : channel_io_a_i;
   assign mirror_b = oe_b ? out_b : channel_io_b_i;

   // pin next values; actions only act in waveform mode
   always_comb
   begin
      next_oe_a = wave;
      next_oe_b = b_is_output;
      next_out_a = out_a;
      next_out_b = out_b;
      if (wave)
         next_out_a = apply_action(
            pick_action(soft_trig, evt_hit, c_match, a_match,
                        mode.out_a_action_on_soft_trigger,
                        mode.out_a_action_on_event,
                        mode.out_a_action_on_c_match,
                        mode.out_a_action_on_a_match),
            out_a);
      // io_b keeps its level while it serves as event input
      if (b_is_output)
         next_out_b = apply_action(
            pick_action(soft_trig, evt_hit, c_match, b_match,
                        mode.out_b_action_on_soft_trigger,
                        mode.out_b_action_on_event,
                        mode.out_b_action_on_c_match,
                        mode.out_b_action_on_b_match),
            out_b);
   end

   // pin flops
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         out_a <= 1'b0;
         out_b <= 1'b0;
         oe_a <= 1'b0;
         oe_b <= 1'b0;
      end
      else
      begin
         out_a <= next_out_a;
         out_b <= next_out_b;
         oe_a <= next_oe_a;
         oe_b <= next_oe_b;
      end
   end

   assign channel_io_a_o = out_a;
   assign channel_io_a_oe_o = oe_a;
   assign channel_io_b_o = out_b;
   assign channel_io_b_oe_o = oe_b;

   // checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence trig_s;
      soft_trig;
   endsequence

   sequence zeroed_s;
      count == CNT_ZERO && !clk_stopped;
   endsequence

   soft_restart_a: assert property (trig_s |=> zeroed_s)
      else $error("software trigger did not restart counter");

   count_read_a: assert property (
      rd_i && addr8 == OFS_COUNT |=> rdata_o == 32'($past(count)))
      else $error("count read wrong");

   stop_on_c_a: assert property (
      c_match && mode.stop_on_c_match && !soft_trig && !restart
      |=> clk_stopped ##1 $stable(count))
      else $error("clock not stopped on c match");

   disable_on_c_a: assert property (
      c_match && mode.disable_on_c_match |=> !clk_enabled)
      else $error("clock not disabled on c match");

   io_b_input_a: assert property (
      mode.event_source_sel == 2'b00 |=> !channel_io_b_oe_o)
      else $error("io_b driven while event input");

   cmp_a_lock_a: assert property (
      wr_i && addr8 == OFS_CMP_A && !wave |=> $stable(cmp_a))
      else $error("compare a written in capture mode");

   cmp_c_write_a: assert property (
      wr_i && addr8 == OFS_CMP_C
      |=> cmp_c == $past(wdata_i[CNT_WIDTH-1:0]))
      else $error("compare c not written");

   set_on_a_a: assert property (
      wave && a_match && !soft_trig && !evt_hit && !c_match
      && mode.out_a_action_on_a_match == ACT_SET
      |=> channel_io_a_o)
      else $error("io_a not set on a match");

   event_restart_a: assert property (
      restart && !soft_trig |=> count == CNT_ZERO)
      else $error("event did not restart counter");

   idle_count_a: assert property (
      !running && !soft_trig && !restart |=> $stable(count))
      else $error("counter moved while clock off");

endmodule : timer_channel_waveform_mode
`default_nettype wire

// ### bench/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
// far side of the channel: clock sources and the two channel pins
module pin_partner (
   input wire logic clk_i, // system clock
   input wire logic a_o_i, // io_a drive level
   input wire logic a_oe_i, // io_a driven
   input wire logic b_o_i, // io_b drive level
   input wire logic b_oe_i, // io_b driven
   output logic [7:0] src_o, // 4:0 internal clocks, 7:5 external
   output logic a_i_o, // io_a wire level
   output logic b_i_o // io_b wire level
);
   logic drv_b; // our own level on io_b when it is an input
   initial
   begin
      src_o = 8'h00;
      drv_b = 1'b0;
   end
   // no pull on io_a, so a released pin shows the inverse value
   assign a_i_o = a_oe_i ? a_o_i : ~a_o_i;
   assign b_i_o = b_oe_i ? b_o_i : drv_b;
   // one level change, held two cycles so the counter can see it
   task automatic edge_to(input int line, input logic lvl);
      @(posedge clk_i);
      if (line < 8)
         src_o[line] <= lvl;
      else
         drv_b <= lvl;
      @(posedge clk_i);
   endtask : edge_to
   // whole periods: rise then fall
   task automatic pulse(input int line, input int n);
      repeat (n)
      begin
         edge_to(line, 1'b1);
         edge_to(line, 1'b0);
      end
   endtask : pulse
endmodule : pin_partner
`default_nettype wire

// ### bench/tb_timer_channel_waveform_mode.sv
`timescale 1ns/1ps
`default_nettype none
module tb_timer_channel_waveform_mode;
   import timer_wave_pkg::*;
   logic clk_i, rst_i, wr_i, rd_i;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic [7:0] src; // clock source levels from the partner
   logic a_o, a_oe, a_in, b_o, b_oe, b_in;
   int error_cnt = 0;
   int n_tests = 0;
   mode_s m; // mode word being built
   timer_channel_waveform_mode timer_channel_waveform_mode_i (
      .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .internal_clock_i(src[4:0]), .ext_clock_i(src[7:5]),
      .channel_io_a_i(a_in), .channel_io_a_o(a_o),
      .channel_io_a_oe_o(a_oe), .channel_io_b_i(b_in),
      .channel_io_b_o(b_o), .channel_io_b_oe_o(b_oe));
   pin_partner pin_partner_i (.clk_i(clk_i), .a_o_i(a_o), .a_oe_i(a_oe),
      .b_o_i(b_o), .b_oe_i(b_oe), .src_o(src), .a_i_o(a_in), .b_i_o(b_in));
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] ex,
                      input logic [31:0] got);
      n_tests++;
      if (got !== ex)
      begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, ex, got);
      end
   endtask : chk
   // one-cycle write strobe
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= ad;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= ad;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask : rd
   task automatic rchk(input string nm, input logic [7:0] ad,
                       input logic [31:0] ex);
      logic [31:0] d;
      rd(ad, d);
      chk(nm, ex, d);
   endtask : rchk
   task automatic cmd(input int b);
      wr(OFS_CONTROL, 32'h0000_0001 << b);
   endtask : cmd
   // pins move one cycle after their cause; allow margin
   task automatic pins(input logic ea, input logic eb);
      repeat (3) @(posedge clk_i);
      #1;
      chk("io_a", {31'h0, ea}, {31'h0, a_o});
      chk("io_b", {31'h0, eb}, {31'h0, b_o});
   endtask : pins
   // own model of an output action
   function automatic logic nxt(input act_e a, input logic c);
      return (a == ACT_SET) | ((a == ACT_TOGGLE) & ~c) | ((a == ACT_NONE) & c);
   endfunction : nxt
   task automatic t_regs();
      rchk("mode", OFS_MODE, MODE_RESET);
      rchk("count", OFS_COUNT, 32'h0000_0000);
      rchk("unmapped", 8'h08, 32'h0000_0000);
      wr(OFS_CMP_A, 32'h0000_1234);
      rchk("a capture", OFS_CMP_A, 32'h0000_0000);
      wr(OFS_CMP_C, 32'hABCD_FFFF);
      rchk("c", OFS_CMP_C, 32'h0000_FFFF);
      m = '0;
      m.waveform_mode_sel = 1'b1;
      wr(OFS_MODE, m);
      wr(OFS_CMP_A, 32'hFFFF_1234);
      wr(OFS_CMP_B, 32'h0000_5678);
      rchk("a wave", OFS_CMP_A, 32'h0000_1234);
      rchk("b wave", OFS_CMP_B, 32'h0000_5678);
      chk("oe_a", 32'h0000_0001, {31'h0, a_oe});
      $display("test registers done");
   endtask : t_regs
   task automatic t_clk();
      cmd(CTRL_CLK_ON_BIT);
      for (int s = 0; s < 8; s++)
      begin
         m.clock_source_sel = s[2:0];
         wr(OFS_MODE, m);
         cmd(CTRL_SOFT_TRIG_BIT);
         pin_partner_i.pulse((s + 1) % 8, 1); // unselected line is ignored
         pin_partner_i.pulse(s, 2);
         rchk("count src", OFS_COUNT, 32'h0000_0002);
      end
      m.clock_source_sel = 3'h0;
      m.count_edge_invert = 1'b1;
      wr(OFS_MODE, m);
      cmd(CTRL_SOFT_TRIG_BIT);
      pin_partner_i.edge_to(0, 1'b1);
      rchk("inv rise", OFS_COUNT, 32'h0000_0000);
      pin_partner_i.edge_to(0, 1'b0);
      rchk("inv fall", OFS_COUNT, 32'h0000_0001);
      m.count_edge_invert = 1'b0;
      m.clock_gate_sel = 2'h2;
      wr(OFS_MODE, m);
      cmd(CTRL_SOFT_TRIG_BIT);
      pin_partner_i.pulse(0, 2);
      rchk("gated", OFS_COUNT, 32'h0000_0000);
      pin_partner_i.edge_to(6, 1'b1);
      pin_partner_i.pulse(0, 2);
      rchk("gate open", OFS_COUNT, 32'h0000_0002);
      pin_partner_i.edge_to(6, 1'b0);
      m.clock_gate_sel = 2'h0;
      $display("test clock done");
   endtask : t_clk
   task automatic t_soft();
      act_e sq[5];
      logic ea, eb;
      sq = '{ACT_CLEAR, ACT_SET, ACT_TOGGLE, ACT_TOGGLE, ACT_NONE};
      ea = 1'b0;
      eb = 1'b0;
      m.event_source_sel = 2'h3; // keeps io_b an output
      for (int i = 0; i < 5; i++)
      begin
         m.out_a_action_on_soft_trigger = sq[i];
         m.out_b_action_on_soft_trigger = sq[(5 - i) % 5];
         wr(OFS_MODE, m);
         pin_partner_i.pulse(0, 1);
         cmd(CTRL_SOFT_TRIG_BIT);
         ea = nxt(sq[i], ea);
         eb = nxt(sq[(5 - i) % 5], eb);
         pins(ea, eb);
         rchk("trig count", OFS_COUNT, 32'h0000_0000);
      end
      $display("test soft trigger done");
   endtask : t_soft
   task automatic t_match();
      m.out_a_action_on_a_match = ACT_SET;
      m.out_a_action_on_c_match = ACT_CLEAR;
      m.out_b_action_on_b_match = ACT_TOGGLE;
      m.out_b_action_on_c_match = ACT_TOGGLE;
      m.out_a_action_on_soft_trigger = ACT_CLEAR;
      m.out_b_action_on_soft_trigger = ACT_CLEAR;
      m.stop_on_c_match = 1'b1;
      wr(OFS_CMP_A, 32'h0000_0002);
      wr(OFS_CMP_B, 32'h0000_0003);
      wr(OFS_CMP_C, 32'h0000_0005);
      wr(OFS_MODE, m);
      cmd(CTRL_SOFT_TRIG_BIT);
      pin_partner_i.pulse(0, 2);
      pins(1'b1, 1'b0);
      pin_partner_i.pulse(0, 1);
      pins(1'b1, 1'b1);
      pin_partner_i.pulse(0, 2);
      pins(1'b0, 1'b0);
      pin_partner_i.pulse(0, 2);
      rchk("stopped", OFS_COUNT, 32'h0000_0005);
      m.stop_on_c_match = 1'b0;
      m.disable_on_c_match = 1'b1;
      wr(OFS_MODE, m);
      cmd(CTRL_SOFT_TRIG_BIT);
      pin_partner_i.pulse(0, 7);
      rchk("disabled", OFS_COUNT, 32'h0000_0005);
      rchk("status", OFS_STATUS, 32'h0000_0000);
      wr(OFS_CONTROL, 32'h0000_0003);
      rchk("clk off", OFS_STATUS, 32'h0000_0000);
      cmd(CTRL_CLK_ON_BIT);
      $display("test match done");
   endtask : t_match
   task automatic t_shape();
      int ex[4];
      ex = '{4, 4, 0, 2}; // up, triangle, up auto, triangle auto
      m = '0;
      m.waveform_mode_sel = 1'b1;
      wr(OFS_CMP_C, 32'h0000_0003);
      for (int sh = 0; sh < 4; sh++)
      begin
         {m.auto_trigger_on_c, m.triangle_count} = sh[1:0];
         wr(OFS_MODE, m);
         cmd(CTRL_SOFT_TRIG_BIT);
         pin_partner_i.pulse(0, 4);
         rchk("shape", OFS_COUNT, 32'(ex[sh]));
      end
      $display("test shape done");
   endtask : t_shape
   task automatic t_event();
      logic r, f;
      m = '0;
      m.waveform_mode_sel = 1'b1;
      m.event_source_sel = 2'h1;
      m.out_a_action_on_event = ACT_TOGGLE;
      m.out_b_action_on_event = ACT_SET;
      m.out_a_action_on_soft_trigger = ACT_CLEAR;
      m.out_b_action_on_soft_trigger = ACT_CLEAR;
      for (int e = 0; e < 4; e++)
      begin
         m.event_edge_sel = edge_e'(e);
         {f, r} = e[1:0];
         wr(OFS_MODE, m);
         cmd(CTRL_SOFT_TRIG_BIT);
         pin_partner_i.pulse(0, 1);
         pin_partner_i.edge_to(5, 1'b1);
         pins(r, r);
         pin_partner_i.edge_to(5, 1'b0);
         pins(r ^ f, r | f);
         rchk("no restart", OFS_COUNT, 32'h0000_0001);
      end
      chk("oe_b out", 32'h0000_0001, {31'h0, b_oe});
      m.event_restart_en = 1'b1;
      m.event_edge_sel = EDGE_RISE;
      wr(OFS_MODE, m);
      pin_partner_i.pulse(0, 2);
      pin_partner_i.edge_to(5, 1'b1);
      rchk("restart", OFS_COUNT, 32'h0000_0000);
      pin_partner_i.edge_to(5, 1'b0);
      m.event_source_sel = 2'h0; // io_b becomes the event input
      wr(OFS_MODE, m);
      pin_partner_i.pulse(0, 2);
      pin_partner_i.edge_to(8, 1'b1);
      rchk("io_b event", OFS_COUNT, 32'h0000_0000);
      chk("oe_b in", 32'h0000_0000, {31'h0, b_oe});
      pin_partner_i.edge_to(8, 1'b0);
      $display("test event done");
   endtask : t_event
   // bounds the whole run
   initial
   begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      complete_run();
   end
   initial
   begin
      rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 32'h0000_0000;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_clk();
      t_soft();
      t_match();
      t_shape();
      t_event();
      complete_run();
   end
endmodule : tb_timer_channel_waveform_mode
`default_nettype wire
